// *** common/om_pkg.sv ***
package om_pkg;
  // ==================== Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYC_PER_MS     = CLK_HZ / MS_PER_S;
  localparam int BLINK_HZ       = 2;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam logic [15:0] LAMP_MS         = 16'h07d0;
  localparam logic [15:0] IO_WINDOW_MS_RST = 16'hea60;
  // ==================== Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SLOT   = 8'h04;
  localparam logic [7:0] ADDR_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [1:0] CTRL_RST    = 2'h0;
  localparam logic [15:0] SLOT_RST   = 16'h0000;
  localparam int CTRL_PREV_BIT   = 0;
  localparam int CTRL_IGNORE_BIT = 1;
  localparam int CMD_RUN_BIT     = 0;
  localparam int CMD_STOP_BIT    = 1;
  localparam int NUM_SLOTS       = 8;
  // ==================== Modes and states
  localparam logic [1:0] MODE_STOP    = 2'h0;
  localparam logic [1:0] MODE_STARTUP = 2'h1;
  localparam logic [1:0] MODE_RUN     = 2'h2;
  localparam logic [1:0] MODE_INIT    = 2'h3;
  typedef enum logic [2:0] {
    OM_LAMP, OM_INIT, OM_STOP, OM_STARTUP, OM_RUN, OM_EVAL, OM_MRES
  } om_state_t;
endpackage : om_pkg

// *** tb/om_far_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==================== Card reader and I/O modules
module om_far_model (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        startup_entry_i,
  input  wire logic        match_cfg_i,
  input  wire logic [15:0] io_delay_i,
  output logic             card_eval_done_o,
  output logic             card_match_o,
  output logic             io_ready_o
);
  logic [15:0] eval_cnt_r;
  logic [15:0] io_cnt_r;
  logic        io_run_r;
  // Evaluation answers only while mode 3 is shown
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || mode_i != 2'h3)
      eval_cnt_r <= 16'h0000;
    else if (eval_cnt_r != 16'h0014)
      eval_cnt_r <= eval_cnt_r + 16'h0001;
  end
  assign card_eval_done_o = (eval_cnt_r == 16'h0014);
  // Match line is inverted outside done so no stale value helps
  assign card_match_o = card_eval_done_o ? match_cfg_i : ~match_cfg_i;
  // I/O powered at startup entry, ready after io_delay_i; ffff never
  always_ff @(posedge clock_i) begin
    if (startup_entry_i) begin
      io_run_r <= 1'b1;
      io_cnt_r <= 16'h0000;
    end else if (!rst_n_i || mode_i == 2'h0) begin
      io_run_r <= 1'b0;
      io_cnt_r <= 16'h0000;
    end else if (io_run_r && io_cnt_r != 16'hfffe) begin
      io_cnt_r <= io_cnt_r + 16'h0001;
    end
  end
  assign io_ready_o = io_run_r && (io_cnt_r >= io_delay_i);
endmodule : om_far_model
`default_nettype wire

// *** tb/om_mode_fsm_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
module om_mode_fsm_bench;
  import om_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        sel_run = 1'b0;
  logic        cons    = 1'b0;
  logic        card_ok = 1'b1;
  logic        hw_cfg  = 1'b1;
  logic        chg     = 1'b0;
  logic        mcfg    = 1'b1;
  logic        was_run = 1'b0;
  logic [3:0]  cause   = 4'h0;
  logic        vars    = 1'b0;
  logic        su_done = 1'b0;
  logic [15:0] io_dly  = 16'h0005;
  logic [7:0]  slot_ok = 8'hff;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [1:0]  mode;
  logic        pready, pslverr, er, eval_done, match, io_rdy;
  logic        yel, grn, flt, mnt, clr, mres;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          n_clr = 0;
  int          n_mres = 0;
  int          waited, tg, eq, c0;
  logic [1:0]  t_ctrl [5] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0};
  logic [15:0] t_slot [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0101};
  logic [7:0]  t_ok   [5] = '{8'hff, 8'hff, 8'hfe, 8'hfe, 8'hfe};
  logic [15:0] t_io   [5] = '{16'hffff, 16'hffff, 16'h0005, 16'h0005, 16'h0005};
  logic [1:0]  t_exp  [5] = '{MODE_STOP, MODE_RUN, MODE_STOP, MODE_STOP, MODE_RUN};
  always #50 clock_i = ~clock_i;
  om_mode_fsm #(.BLINK_HALF(4), .CYC_PER_MS(2)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .selector_run_i(sel_run), .consistent_i(cons), .hw_config_loaded_i(hw_cfg),
    .card_valid_i(card_ok), .card_change_i(chg), .card_eval_done_i(eval_done),
    .card_match_i(match), .was_run_i(was_run), .startup_error_i(cause[0]),
    .startup_stop_i(cause[1]), .program_variables_init_i(vars),
    .startup_done_i(su_done), .fatal_error_i(cause[2]), .program_stop_i(cause[3]),
    .io_ready_i(io_rdy), .slot_compatible_i(slot_ok), .mode_o(mode),
    .run_stop_yellow_o(yel), .run_stop_green_o(grn), .fault_indicator_o(flt),
    .maintenance_indicator_o(mnt), .clear_nonretentive_o(clr), .memory_reset_o(mres));
  om_far_model far (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode), .startup_entry_i(clr),
    .match_cfg_i(mcfg), .io_delay_i(io_dly), .card_eval_done_o(eval_done),
    .card_match_o(match), .io_ready_o(io_rdy));
  // ==================== Tasks
  task automatic results();
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_mode(input logic [1:0] m, input int lim);
    waited = 0;
    while (mode !== m && waited < lim) begin
      @(posedge clock_i);
      waited++;
    end
    `CHK("mode", m, mode)
  endtask : wait_mode
  // Counts toggles of yellow (y) or fault, and cycles with yellow equal to green or fault unlike maintenance
  task automatic tog(input int n, input logic y);
    logic last;
    tg = 0;
    eq = 0;
    @(posedge clock_i);
    last = y ? yel : flt;
    repeat (n) begin
      @(posedge clock_i);
      if ((y ? yel : flt) !== last) tg++;
      if (yel === grn || flt !== mnt) eq++;
      last = y ? yel : flt;
    end
  endtask : tog
  task automatic power_up(input logic [31:0] ctrl);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    apb(1'b0, ADDR_WINDOW, 32'h0000_0000);
    `CHK("window_rst", 32'h0000_ea60, rd)
    apb(1'b0, ADDR_SLOT, 32'h0000_0000);
    `CHK("slot_rst", 32'h0000_0000, rd)
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, ADDR_CTRL, ctrl);
    apb(1'b1, ADDR_WINDOW, 32'h0000_00c8);
  endtask : power_up
  // ==================== Monitors and watchdog
  always @(posedge clock_i) begin
    if (clr === 1'b1) n_clr++;
    if (mres === 1'b1) n_mres++;
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    mismatches++;
    results();
  end
  // ==================== Tests
  initial begin
    power_up(32'h0000_0000);
    tog(40, 1'b0);
    `CHK("lamp_blink", 1'b1, tg >= 9 && tg <= 10)
    `CHK("lamp_colours", 0, eq)
    wait_mode(MODE_STOP, 5000);
    tog(12, 1'b1);
    `CHK("stop_steady", 0, tg)
    `CHK("stop_lamp", 2'b10, {yel, grn})
    cons    <= 1'b1;
    sel_run <= 1'b1;
    power_up(32'h0000_0001);
    wait_mode(MODE_STOP, 5000);
    was_run <= 1'b1;
    power_up(32'h0000_0001);
    wait_mode(MODE_STARTUP, 5000);
    c0 = n_clr;
    for (int k = 0; k < 9; k++) begin
      sel_run <= 1'b0;
      repeat (3) @(posedge clock_i);
      sel_run <= 1'b1;
      wait_mode(MODE_STARTUP, 20);
      if (k >= 4 && k < 8) begin
        vars    <= 1'b1;
        su_done <= 1'b1;
        wait_mode(MODE_RUN, 40);
      end
      case (k)
        0: cause[0] <= 1'b1;
        1: cause[1] <= 1'b1;
        3: card_ok  <= 1'b0;
        4: cause[2] <= 1'b1;
        5: cause[3] <= 1'b1;
        7: sel_run  <= 1'b0;
        8: hw_cfg   <= 1'b0;
        default: apb(1'b1, ADDR_CMD, 32'h0000_0002);
      endcase
      wait_mode(MODE_STOP, 30);
      cause   <= 4'h0;
      card_ok <= 1'b1;
      hw_cfg  <= 1'b1;
      vars    <= 1'b0;
      su_done <= 1'b0;
    end
    `CHK("clear_pulses", 9, n_clr - c0)
    // Selector already at RUN: a fresh rising edge here would start up early
    @(posedge clock_i);
    sel_run <= 1'b1;
    vars    <= 1'b1;
    su_done <= 1'b1;
    for (int j = 0; j < 5; j++) begin
      apb(1'b1, ADDR_CTRL, {30'h0, t_ctrl[j]});
      apb(1'b1, ADDR_SLOT, {16'h0, t_slot[j]});
      apb(1'b1, ADDR_WINDOW, 32'h0000_000a);
      slot_ok <= t_ok[j];
      io_dly  <= t_io[j];
      apb(1'b1, ADDR_CMD, 32'h0000_0001);
      wait_mode(MODE_STARTUP, 10);
      wait_mode(t_exp[j], 40);
      if (j == 0) `CHK("window_len", 1'b1, waited >= 17 && waited <= 24)
      if (j < 4) begin
        cause[3] <= 1'b1;
        @(posedge clock_i);
        wait_mode(MODE_STOP, 10);
        cause[3] <= 1'b0;
      end
    end
    c0 = n_mres;
    chg <= 1'b1;
    @(posedge clock_i);
    chg <= 1'b0;
    wait_mode(MODE_INIT, 5);
    tog(12, 1'b1);
    `CHK("eval_blink", 1'b1, tg >= 2)
    wait_mode(MODE_RUN, 40);
    mcfg <= 1'b0;
    chg  <= 1'b1;
    @(posedge clock_i);
    chg <= 1'b0;
    wait_mode(MODE_STOP, 60);
    `CHK("mem_reset", 1, n_mres - c0)
    results();
  end
endmodule : om_mode_fsm_bench
`default_nettype wire

// *** verilog/om_blink.sv ***
`timescale 1ns/1ns
`default_nettype none
module om_blink #(
  parameter int HALF_CYC = om_pkg::BLINK_HALF_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  output logic      phase_o
);
  import om_pkg::*;
  logic [31:0] cnt_r;

  // ==================== Half-period toggle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_r   <= 32'h0000_0000;
      phase_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt_r == 32'(HALF_CYC - 1)) begin
        cnt_r   <= 32'h0000_0000;
        phase_o <= !phase_o;
      end else begin
        cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  end

  property p_phase_steady;
    @(posedge clock_i) disable iff (!rst_n_i)
      (cnt_r != 32'(HALF_CYC - 1)) |=> $stable(phase_o);
  endproperty
  a_phase_steady: assert property (p_phase_steady)
    else $error("blink phase moved mid period");
endmodule : om_blink
`default_nettype wire

// *** verilog/om_mode_fsm.sv ***
// Function
// - On card insert/remove in STOP, STARTUP or RUN, compare card with retentive data.
// - Card mismatch forces a memory reset, then STOP.
// - Run/stop indicator flashes during card evaluation.
// - Power-on lamp test, all indicators flashing at 2 Hz.
// - Then initialisation with card evaluation, run/stop flashing yellow 2 Hz.
// - After initialisation, STOP with steady yellow run/stop indicator.
// - Exactly STARTUP, RUN, STOP; network stays up; mode shown on indicators.
// - Power-on goes to STARTUP if consistent and startup type permits.
// - Entering STARTUP clears non-retentive memory, keeps retentive data.
// - STOP to STARTUP on consistent configuration plus a run request.
// - STARTUP to STOP on error, stop request or routine STOP command.
// - STARTUP to RUN after variables initialised and startup routines done.
// - RUN to STOP on fatal error, program STOP or stop request.
// - Compatibility setting: compatible-only or ignore-mismatch startup.
// - Per-slot compatibility setting overrides the device-wide one, except at window end, which also needs the device-wide ignore bit.
// - I/O readiness window, default 60000 ms; ready in time goes RUN.
// - I/O not ready at window end: compatibility setting decides.
// - No valid card or no hardware configuration blocks or cancels startup.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module om_mode_fsm #(
  parameter int BLINK_HALF = om_pkg::BLINK_HALF_CYC,
  parameter int CYC_PER_MS = om_pkg::CYC_PER_MS
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         ce_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [7:0]                   paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  output logic      [31:0]                  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  input  wire logic                         selector_run_i,
  input  wire logic                         consistent_i,
  input  wire logic                         hw_config_loaded_i,
  input  wire logic                         card_valid_i,
  input  wire logic                         card_change_i,
  input  wire logic                         card_eval_done_i,
  input  wire logic                         card_match_i,
  input  wire logic                         was_run_i,
  input  wire logic                         startup_error_i,
  input  wire logic                         startup_stop_i,
  input  wire logic                         program_variables_init_i,
  input  wire logic                         startup_done_i,
  input  wire logic                         fatal_error_i,
  input  wire logic                         program_stop_i,
  input  wire logic                         io_ready_i,
  input  wire logic [om_pkg::NUM_SLOTS-1:0] slot_compatible_i,
  output logic      [1:0]                   mode_o,
  output logic                              run_stop_yellow_o,
  output logic                              run_stop_green_o,
  output logic                              fault_indicator_o,
  output logic                              maintenance_indicator_o,
  output logic                              clear_nonretentive_o,
  output logic                              memory_reset_o
);
  import om_pkg::*;

  om_state_t             state_r;
  om_state_t             state_nxt;
  om_state_t             back_r;
  logic [1:0]            ctrl_r;
  logic [15:0]           slot_r;
  logic [15:0]           window_r;
  logic                  cmd_run_r;
  logic                  cmd_stop_r;
  logic                  sel_prev_r;
  logic                  blink;
  logic                  lamp_done;
  logic                  win_expired;
  logic                  lamp_start_r;
  logic                  win_start;
  logic                  wr_en;
  logic                  rd_en;
  logic                  card_ok;
  logic                  stop_req;
  logic                  run_req;
  logic                  compat_ok;
  logic [NUM_SLOTS-1:0]  slot_ign;

  // ==================== APB slave
  assign pready_o = ce_i;
  assign wr_en    = psel_i && penable_i && pwrite_i && ce_i;
  assign rd_en    = psel_i && penable_i && !pwrite_i && ce_i;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_r   <= CTRL_RST;
      slot_r   <= SLOT_RST;
      window_r <= IO_WINDOW_MS_RST;
    end else if (wr_en) begin
      if (paddr_i == ADDR_CTRL) begin
        ctrl_r <= pwdata_i[1:0];
      end else if (paddr_i == ADDR_SLOT) begin
        slot_r <= pwdata_i[15:0];
      end else if (paddr_i == ADDR_WINDOW) begin
        window_r <= pwdata_i[15:0];
      end
    end
  end

  // Command bits are one-cycle pulses; they never read back
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cmd_run_r  <= 1'b0;
      cmd_stop_r <= 1'b0;
    end else if (ce_i) begin
      cmd_run_r  <= wr_en && (paddr_i == ADDR_CMD) && pwdata_i[CMD_RUN_BIT];
      cmd_stop_r <= wr_en && (paddr_i == ADDR_CMD) && pwdata_i[CMD_STOP_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        if (paddr_i == ADDR_CTRL) begin
          prdata_o <= {30'h0000_0000, ctrl_r};
        end else if (paddr_i == ADDR_SLOT) begin
          prdata_o <= {16'h0000, slot_r};
        end else if (paddr_i == ADDR_WINDOW) begin
          prdata_o <= {16'h0000, window_r};
        end else if (paddr_i == ADDR_STATUS) begin
          prdata_o <= {24'h00_0000, state_r, win_expired, io_ready_i, 1'b0, mode_o};
        end else if (paddr_i != ADDR_CMD) begin
          pslverr_o <= 1'b1;
        end
      end else if (!rd_en) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // ==================== Timers and blink
  om_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .phase_o (blink)
  );

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lamp_start_r <= 1'b1;
    end else if (ce_i) begin
      lamp_start_r <= 1'b0;
    end
  end

  om_timer #(.CYC_PER_MS(CYC_PER_MS)) u_lamp (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .start_i   (lamp_start_r),
    .len_ms_i  (LAMP_MS),
    .expired_o (lamp_done)
  );

  assign win_start = (state_nxt == OM_STARTUP) && (state_r != OM_STARTUP);

  om_timer #(.CYC_PER_MS(CYC_PER_MS)) u_window (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .start_i   (win_start),
    .len_ms_i  (window_r),
    .expired_o (win_expired)
  );

  // ==================== Request decode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sel_prev_r <= 1'b0;
    end else if (ce_i) begin
      sel_prev_r <= selector_run_i;
    end
  end

  assign card_ok  = card_valid_i && hw_config_loaded_i;
  assign stop_req = cmd_stop_r || !selector_run_i;
  assign run_req  = (cmd_run_r && selector_run_i) || (selector_run_i && !sel_prev_r);

  // Per-slot override wins over the device-wide setting
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_ign[i] = slot_r[i] ? slot_r[NUM_SLOTS + i] : ctrl_r[CTRL_IGNORE_BIT];
    end
  end
  assign compat_ok = &(slot_compatible_i | slot_ign);

  // ==================== Mode sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OM_LAMP: begin
        if (lamp_done) begin
          state_nxt = OM_INIT;
        end
      end
      OM_INIT: begin
        if (card_eval_done_i) begin
          if (consistent_i && card_ok &&
              (!ctrl_r[CTRL_PREV_BIT] || was_run_i)) begin
            state_nxt = OM_STARTUP;
          end else begin
            state_nxt = OM_STOP;
          end
        end
      end
      OM_STOP: begin
        if (card_change_i) begin
          state_nxt = OM_EVAL;
        end else if (consistent_i && card_ok && run_req) begin
          state_nxt = OM_STARTUP;
        end
      end
      OM_STARTUP: begin
        if (card_change_i) begin
          state_nxt = OM_EVAL;
        end else if (!card_ok || startup_error_i || stop_req || startup_stop_i) begin
          state_nxt = OM_STOP;
        end else if (program_variables_init_i && startup_done_i) begin
          if (io_ready_i && compat_ok) begin
            state_nxt = OM_RUN;
          end else if (win_expired) begin
            // Unready I/O is tolerated only in ignore-mismatch mode
            state_nxt = (ctrl_r[CTRL_IGNORE_BIT] && compat_ok) ? OM_RUN : OM_STOP;
          end
        end
      end
      OM_RUN: begin
        if (card_change_i) begin
          state_nxt = OM_EVAL;
        end else if (fatal_error_i || program_stop_i || stop_req) begin
          state_nxt = OM_STOP;
        end
      end
      OM_EVAL: begin
        if (card_eval_done_i) begin
          if (!card_match_i) begin
            state_nxt = OM_MRES;
          end else if (back_r != OM_STOP && !card_ok) begin
            state_nxt = OM_STOP;
          end else begin
            state_nxt = back_r;
          end
        end
      end
      OM_MRES: begin
        state_nxt = OM_STOP;
      end
      default: begin
        state_nxt = OM_STOP;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= OM_LAMP;
      back_r  <= OM_STOP;
    end else if (ce_i) begin
      state_r <= state_nxt;
      if (state_nxt == OM_EVAL && state_r != OM_EVAL) begin
        back_r <= state_r;
      end
    end
  end

  // Entry pulses; retentive data is untouched by the STARTUP clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clear_nonretentive_o <= 1'b0;
      memory_reset_o       <= 1'b0;
    end else if (ce_i) begin
      clear_nonretentive_o <= win_start;
      memory_reset_o       <= (state_nxt == OM_MRES);
    end
  end

  // ==================== Indicators
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_o                  <= MODE_INIT;
      run_stop_yellow_o       <= 1'b0;
      run_stop_green_o        <= 1'b0;
      fault_indicator_o       <= 1'b0;
      maintenance_indicator_o <= 1'b0;
    end else if (ce_i) begin
      fault_indicator_o       <= 1'b0;
      maintenance_indicator_o <= 1'b0;
      run_stop_green_o        <= 1'b0;
      run_stop_yellow_o       <= blink;
      mode_o                  <= MODE_INIT;
      case (state_r)
        OM_LAMP: begin
          run_stop_green_o        <= !blink;
          fault_indicator_o       <= blink;
          maintenance_indicator_o <= blink;
        end
        OM_STOP: begin
          mode_o            <= MODE_STOP;
          run_stop_yellow_o <= 1'b1;
        end
        OM_STARTUP: begin
          mode_o            <= MODE_STARTUP;
          run_stop_yellow_o <= 1'b1;
          run_stop_green_o  <= blink;
        end
        OM_RUN: begin
          mode_o            <= MODE_RUN;
          run_stop_yellow_o <= 1'b0;
          run_stop_green_o  <= 1'b1;
        end
        default: begin
          mode_o <= MODE_INIT;
        end
      endcase
    end
  end

  // ==================== Checks
  property p_eval_flash;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_EVAL) |=> (run_stop_yellow_o == $past(blink) && !run_stop_green_o);
  endproperty
  a_eval_flash: assert property (p_eval_flash)
    else $error("run/stop not flashing in evaluation");

  property p_lamp;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_LAMP) |=>
        (run_stop_green_o != run_stop_yellow_o && fault_indicator_o == $past(blink));
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp test pattern wrong");

  property p_stop_lamp;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_STOP) |=> (run_stop_yellow_o && !run_stop_green_o && mode_o == MODE_STOP);
  endproperty
  a_stop_lamp: assert property (p_stop_lamp)
    else $error("STOP not steady yellow");

  property p_mres;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_EVAL && card_eval_done_i && !card_match_i) |=>
        (memory_reset_o && state_r == OM_MRES) ##1 (!ce_i || state_r == OM_STOP);
  endproperty
  a_mres: assert property (p_mres)
    else $error("mismatch did not reset memory then stop");

  property p_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
      (state_r == OM_STARTUP && $past(state_r) != OM_STARTUP) |-> clear_nonretentive_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("no non-retentive clear on STARTUP entry");

  property p_run_stop;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_RUN && !card_change_i && (fatal_error_i || program_stop_i))
        |=> state_r == OM_STOP;
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("RUN did not stop");

  property p_startup_cancel;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_STARTUP && !card_change_i && (startup_error_i || !card_ok))
        |=> state_r == OM_STOP;
  endproperty
  a_startup_cancel: assert property (p_startup_cancel)
    else $error("startup not cancelled");

  property p_start_req;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_STOP && !card_change_i && consistent_i && card_ok &&
       selector_run_i && !sel_prev_r) |=> state_r == OM_STARTUP;
  endproperty
  a_start_req: assert property (p_start_req)
    else $error("selector STOP to RUN ignored");

  property p_no_early_run;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && state_r == OM_STARTUP && !program_variables_init_i) |=> state_r != OM_RUN;
  endproperty
  a_no_early_run: assert property (p_no_early_run)
    else $error("RUN before variables initialised");
endmodule : om_mode_fsm
`default_nettype wire

// *** verilog/om_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module om_timer #(
  parameter int CYC_PER_MS = om_pkg::CYC_PER_MS
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [15:0] len_ms_i,
  output logic             expired_o
);
  import om_pkg::*;
  logic [31:0] pre_r;
  logic [15:0] ms_r;
  logic        active_r;

  // ==================== Millisecond countdown
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pre_r     <= 32'h0000_0000;
      ms_r      <= 16'h0000;
      active_r  <= 1'b0;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      if (start_i) begin
        pre_r     <= 32'h0000_0000;
        ms_r      <= len_ms_i;
        active_r  <= 1'b1;
        expired_o <= 1'b0;
      end else if (active_r) begin
        if (ms_r == 16'h0000) begin
          expired_o <= 1'b1;
          active_r  <= 1'b0;
        end else if (pre_r == 32'(CYC_PER_MS - 1)) begin
          pre_r <= 32'h0000_0000;
          ms_r  <= ms_r - 16'h0001;
        end else begin
          pre_r <= pre_r + 32'h0000_0001;
        end
      end
    end
  end

  property p_restart_clears;
    @(posedge clock_i) disable iff (!rst_n_i)
      (ce_i && start_i) |=> !expired_o;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("timer expired right after start");
endmodule : om_timer
`default_nettype wire
